// [rtl/serial_flash_command_set.sv]
// Serial flash command layer with a small flip-flop array.
// Link side runs on serialClk; selN ends a frame. Core runs on clk.
`timescale 1ns/1ps
`include "serial_flash_command_set_regs.svh"

module serial_flash_command_set #(
    parameter int          MEM_BYTES    = 16,
    parameter int          PAGE_BYTES   = 4,
    parameter int          SECTOR_BYTES = 4,
    parameter int          BLOCK_BYTES  = 8,
    // Identity values below are arbitrary
    parameter logic [7:0]  MAKER_ID     = 8'hA5,
    parameter logic [7:0]  MEM_TYPE     = 8'h5A,
    parameter logic [7:0]  CAPACITY     = 8'h14,
    parameter logic [7:0]  DEVICE_ID    = 8'h3C,
    parameter logic [7:0]  SIGNATURE    = 8'h13,
    parameter int unsigned STATUS_CYC   = `STATUS_MS * 1000 * `CLK_MHZ,
    parameter int unsigned PAGE_CYC     = `PAGE_MS * 1000 * `CLK_MHZ,
    parameter int unsigned BYTE_CYC     = `BYTE_US * `CLK_MHZ,
    parameter int unsigned SECTOR_CYC   = `SECTOR_MS * 1000 * `CLK_MHZ,
    parameter int unsigned BLOCK_CYC    = `BLOCK_S * 1000000 * `CLK_MHZ,
    parameter int unsigned CHIP_CYC     = `CHIP_S * 1000000 * `CLK_MHZ
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic serialClk,
    input  wire logic selN,
    input  wire logic serialIn,
    input  wire logic pauseN,
    output logic      serialOut,
    output logic      serialOutEn,
    output logic      dualOut,
    output logic      dualOutEn,
    output logic      busyOut,
    output logic      asleepOut
);

    localparam int AW = $clog2(MEM_BYTES);
    localparam int PW = $clog2(PAGE_BYTES);
    localparam logic [31:0] SLEEP_CNT = 32'(`SLEEP_CYC);
    localparam logic [31:0] WAKE_CNT  = 32'(`WAKE_CYC);

    //--------------------------------------------------
    // Link domain state
    //--------------------------------------------------
    logic                                  freshR;
    logic [15:0]                           bitCntR;
    logic [31:0]                           shiftR;
    serial_flash_command_set_pkg::frame_s  frmR;
    logic [7:0]                            pgBufR [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]                 pgMaskR;
    logic [7:0]                            statS1, statS2;
    logic [7:0]                            secS1, secS2;
    logic                                  aslS1, aslS2;

    //--------------------------------------------------
    // Core domain state
    //--------------------------------------------------
    serial_flash_command_set_pkg::core_e   stateR;
    serial_flash_command_set_pkg::frame_s  pendR;
    logic [31:0]                           tmrR;
    logic                                  welR;
    logic [5:0]                            stHiR;
    logic [7:0]                            statR;
    logic [7:0]                            secR;
    logic [7:0]                            memR [MEM_BYTES];
    logic [7:0]                            pgBufC [PAGE_BYTES];
    logic [PAGE_BYTES-1:0]                 pgMaskC;
    logic                                  selS1, selS2, selS3;

    // Whether index i lies in the same area of a given size as the address
    function automatic logic sameArea(input int i, input logic [23:0] a,
                                      input int sz);
        int base;
        base = int'(a[AW-1:0]);
        return (i / sz) == (base / sz);
    endfunction : sameArea

    //--------------------------------------------------
    // Link input shifting
    //--------------------------------------------------
    wire [15:0] cntNxt = freshR ? 16'h0001 :
                         (&bitCntR ? bitCntR : bitCntR + 16'h0001);
    wire [31:0] shNxt    = {shiftR[30:0], serialIn};
    wire [15:0] dataIdx  = cntNxt - `FAST_END;
    wire [PW-1:0] pgIdx  = PW'(frmR.addr[PW-1:0] + dataIdx[PW+2:3]);
    wire        dataDone = (frmR.op == serial_flash_command_set_pkg::OP_PAGE)
                           && (cntNxt >= `FAST_END) && (cntNxt[2:0] == 3'h0);

    // Restart flag and status crossings; deselect sets the flag and clears the crossings
    always_ff @(posedge serialClk or posedge selN) begin
        if (selN) begin
            freshR <= 1'b1;
            statS1 <= 8'h00;
            statS2 <= 8'h00;
            secS1  <= 8'h00;
            secS2  <= 8'h00;
            aslS1  <= 1'b0;
            aslS2  <= 1'b0;
        end else begin
            if (pauseN) begin
                freshR <= 1'b0;
            end
            statS1 <= statR;
            statS2 <= statS1;
            secS1  <= secR;
            secS2  <= secS1;
            aslS1  <= asleepOut;
            aslS2  <= aslS1;
        end
    end

    // Capture survives deselect so the core can read it
    always_ff @(posedge serialClk) begin
        if (pauseN) begin
            shiftR  <= shNxt;
            bitCntR <= cntNxt;
            if (freshR) begin
                pgMaskR <= '0;
            end
            if (cntNxt == `OP_BITS) begin
                frmR.op <= shNxt[7:0];
            end
            if (cntNxt == `STORE_END) begin
                frmR.dat <= shNxt[7:0];
            end
            if (cntNxt == `ADDR_END) begin
                frmR.addr <= shNxt[23:0];
            end
            if (dataDone) begin
                pgBufR[pgIdx]  <= shNxt[7:0];
                pgMaskR[pgIdx] <= 1'b1;
            end
        end
    end

    //--------------------------------------------------
    // Link output selection
    //--------------------------------------------------
    logic [15:0] outStart;
    logic [7:0]  outByte;

    always_comb begin
        outStart = `NO_OUT;
        case (frmR.op)
            serial_flash_command_set_pkg::OP_STAT,
            serial_flash_command_set_pkg::OP_SECRD,
            serial_flash_command_set_pkg::OP_IDENT: begin
                outStart = `OP_BITS;
            end
            serial_flash_command_set_pkg::OP_READ,
            serial_flash_command_set_pkg::OP_WAKE,
            serial_flash_command_set_pkg::OP_MAKER: begin
                outStart = `ADDR_END;
            end
            serial_flash_command_set_pkg::OP_FAST,
            serial_flash_command_set_pkg::OP_DUAL: begin
                outStart = `FAST_END;
            end
            default: begin
                outStart = `NO_OUT;
            end
        endcase
    end

    wire        isDual  = frmR.op == serial_flash_command_set_pkg::OP_DUAL;
    wire [15:0] outPos  = bitCntR - outStart;
    wire [15:0] byteNo  = isDual ? {2'b00, outPos[15:2]} : {3'b000, outPos[15:3]};
    wire [2:0]  bitNo   = isDual ? {outPos[1:0], 1'b0} : outPos[2:0];
    wire [1:0]  idIdx   = 2'(byteNo % 16'h0003);
    wire [AW-1:0] rdIdx = AW'(frmR.addr[AW-1:0] + byteNo[AW-1:0]);
    // While asleep only the wake opcode answers
    wire        outOk   = !freshR && (outStart != `NO_OUT)
                          && (bitCntR >= outStart)
                          && (!aslS2 ||
                              frmR.op == serial_flash_command_set_pkg::OP_WAKE);
    wire        hiBit   = outByte[3'h7 - bitNo];
    wire        loBit   = outByte[3'h6 - bitNo];

    // Array is read across domains; it is static while not busy
    always_comb begin
        outByte = 8'h00;
        case (frmR.op)
            serial_flash_command_set_pkg::OP_STAT: begin
                outByte = statS2;
            end
            serial_flash_command_set_pkg::OP_SECRD: begin
                outByte = secS2;
            end
            serial_flash_command_set_pkg::OP_IDENT: begin
                outByte = (idIdx == 2'h0) ? MAKER_ID :
                          (idIdx == 2'h1) ? MEM_TYPE : CAPACITY;
            end
            serial_flash_command_set_pkg::OP_WAKE: begin
                outByte = SIGNATURE;
            end
            // Address bit 0 picks first code
            serial_flash_command_set_pkg::OP_MAKER: begin
                outByte = (byteNo[0] ^ frmR.addr[0]) ? DEVICE_ID : MAKER_ID;
            end
            serial_flash_command_set_pkg::OP_READ,
            serial_flash_command_set_pkg::OP_FAST,
            serial_flash_command_set_pkg::OP_DUAL: begin
                outByte = memR[rdIdx];
            end
            default: begin
                outByte = 8'h00;
            end
        endcase
    end

    // Outputs change on the falling edge
    always_ff @(negedge serialClk or posedge selN) begin
        if (selN) begin
            serialOut   <= 1'b0;
            serialOutEn <= 1'b0;
            dualOut     <= 1'b0;
            dualOutEn   <= 1'b0;
        end else if (!pauseN) begin
            serialOutEn <= 1'b0;
            dualOutEn   <= 1'b0;
        end else begin
            serialOut   <= hiBit;
            serialOutEn <= outOk;
            dualOut     <= loBit;
            dualOutEn   <= outOk && isDual;
        end
    end

    //--------------------------------------------------
    // Core command decode
    //--------------------------------------------------
    wire [7:0]  op      = frmR.op;
    wire [15:0] nb      = bitCntR;
    wire        selRise = selS2 && !selS3;
    wire        ready   = stateR == serial_flash_command_set_pkg::ST_READY;
    // Modifying only when idle and enabled
    wire        modOk   = selRise && ready && welR;

    wire doWren  = selRise && ready && nb == `OP_BITS
                   && op == serial_flash_command_set_pkg::OP_WRITE_UNLOCK;
    wire doWrdis = selRise && ready && nb == `OP_BITS
                   && op == serial_flash_command_set_pkg::OP_WRDIS;
    wire doStore = modOk && nb == `STORE_END
                   && op == serial_flash_command_set_pkg::OP_STORE;
    wire doSect  = modOk && nb == `ADDR_END
                   && op == serial_flash_command_set_pkg::OP_SECT;
    wire doBlk   = modOk && nb == `ADDR_END
                   && (op == serial_flash_command_set_pkg::OP_BLK_A
                       || op == serial_flash_command_set_pkg::OP_BLK_B);
    wire doChip  = modOk && nb == `OP_BITS
                   && (op == serial_flash_command_set_pkg::OP_CHIP_A
                       || op == serial_flash_command_set_pkg::OP_CHIP_B);
    wire doPage  = modOk && nb >= `BYTE_END && nb[2:0] == 3'h0
                   && op == serial_flash_command_set_pkg::OP_PAGE;
    wire doSecWr = modOk && nb == `OP_BITS
                   && op == serial_flash_command_set_pkg::OP_SECWR;
    wire doSleep = selRise && ready && nb == `OP_BITS
                   && op == serial_flash_command_set_pkg::OP_SLEEP;
    wire doWake  = selRise && nb >= `OP_BITS
                   && stateR == serial_flash_command_set_pkg::ST_ASLP
                   && op == serial_flash_command_set_pkg::OP_WAKE;
    wire startBusy = doStore || doSect || doBlk || doChip || doPage;
    wire tmrDone   = tmrR == 32'h0000_0000;
    wire finish    = tmrDone && stateR == serial_flash_command_set_pkg::ST_BUSY;

    wire [31:0] busyLen = doStore ? STATUS_CYC :
                          doSect  ? SECTOR_CYC :
                          doBlk   ? BLOCK_CYC  :
                          doChip  ? CHIP_CYC   :
                          (nb == `BYTE_END) ? BYTE_CYC : PAGE_CYC;

    // Deselect crosses into the core by two flip-flops
    always_ff @(posedge clk) begin
        if (!nrst) begin
            selS1 <= 1'b1;
            selS2 <= 1'b1;
            selS3 <= 1'b1;
        end else begin
            selS1 <= selN;
            selS2 <= selS1;
            selS3 <= selS2;
        end
    end

    //--------------------------------------------------
    // Core sequencer
    //--------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stateR <= serial_flash_command_set_pkg::ST_READY;
            tmrR   <= 32'h0000_0000;
        end else begin
            case (stateR)
                serial_flash_command_set_pkg::ST_READY: begin
                    if (startBusy) begin
                        stateR <= serial_flash_command_set_pkg::ST_BUSY;
                        tmrR   <= busyLen - 32'h0000_0001;
                    end else if (doSleep) begin
                        stateR <= serial_flash_command_set_pkg::ST_ENTER;
                        tmrR   <= SLEEP_CNT - 32'h0000_0001;
                    end
                end
                serial_flash_command_set_pkg::ST_BUSY: begin
                    if (tmrDone) begin
                        stateR <= serial_flash_command_set_pkg::ST_READY;
                    end else begin
                        tmrR <= tmrR - 32'h0000_0001;
                    end
                end
                serial_flash_command_set_pkg::ST_ENTER: begin
                    if (tmrDone) begin
                        stateR <= serial_flash_command_set_pkg::ST_ASLP;
                    end else begin
                        tmrR <= tmrR - 32'h0000_0001;
                    end
                end
                serial_flash_command_set_pkg::ST_ASLP: begin
                    if (doWake) begin
                        stateR <= serial_flash_command_set_pkg::ST_WAKE;
                        tmrR   <= WAKE_CNT - 32'h0000_0001;
                    end
                end
                serial_flash_command_set_pkg::ST_WAKE: begin
                    if (tmrDone) begin
                        stateR <= serial_flash_command_set_pkg::ST_READY;
                    end else begin
                        tmrR <= tmrR - 32'h0000_0001;
                    end
                end
                default: begin
                    stateR <= serial_flash_command_set_pkg::ST_READY;
                end
            endcase
        end
    end

    // Control and status registers of the core
    always_ff @(posedge clk) begin
        if (!nrst) begin
            welR      <= 1'b0;
            stHiR     <= 6'h00;
            secR      <= 8'h00;
            statR     <= 8'h00;
            busyOut   <= 1'b0;
            asleepOut <= 1'b0;
            pendR     <= '0;
            pgMaskC   <= '0;
        end else begin
            // Enable latch, dropped after each operation
            if (doWren) begin
                welR <= 1'b1;
            end else if (doWrdis || finish || doSecWr) begin
                welR <= 1'b0;
            end
            if (startBusy) begin
                pendR   <= frmR;
                pgMaskC <= pgMaskR;
            end
            if (finish && pendR.op == serial_flash_command_set_pkg::OP_STORE) begin
                stHiR <= pendR.dat[7:2];
            end
            // Lock bit set by security write
            if (doSecWr) begin
                secR[`SEC_LOCK] <= 1'b1;
            end
            statR <= {stHiR, welR, !ready};
            busyOut   <= !ready;
            asleepOut <= stateR == serial_flash_command_set_pkg::ST_ASLP;
        end
    end

    //--------------------------------------------------
    // Array update at completion
    //--------------------------------------------------
    always_ff @(posedge clk) begin
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (startBusy) begin
                pgBufC[i] <= pgBufR[i];
            end
        end
        for (int i = 0; i < MEM_BYTES; i++) begin
            if (!nrst) begin
                memR[i] <= 8'hFF;
            end else if (finish) begin
                case (pendR.op)
                    serial_flash_command_set_pkg::OP_SECT: begin
                        if (sameArea(i, pendR.addr, SECTOR_BYTES)) begin
                            memR[i] <= 8'hFF;
                        end
                    end
                    serial_flash_command_set_pkg::OP_BLK_A,
                    serial_flash_command_set_pkg::OP_BLK_B: begin
                        if (sameArea(i, pendR.addr, BLOCK_BYTES)) begin
                            memR[i] <= 8'hFF;
                        end
                    end
                    serial_flash_command_set_pkg::OP_CHIP_A,
                    serial_flash_command_set_pkg::OP_CHIP_B: begin
                        memR[i] <= 8'hFF;
                    end
                    serial_flash_command_set_pkg::OP_PAGE: begin
                        if (sameArea(i, pendR.addr, PAGE_BYTES)
                            && pgMaskC[i % PAGE_BYTES]) begin
                            memR[i] <= memR[i] & pgBufC[i % PAGE_BYTES];
                        end
                    end
                    default: begin
                        memR[i] <= memR[i];
                    end
                endcase
            end
        end
    end

endmodule : serial_flash_command_set

// [rtl/serial_flash_command_set_pkg.sv]
// Types of the flash command layer.
// Numeric constants live in the _regs header.
package serial_flash_command_set_pkg;

    typedef enum logic [7:0] {
        OP_WRITE_UNLOCK   = 8'h06,
        OP_WRDIS  = 8'h04,
        OP_STAT   = 8'h05,
        OP_STORE  = 8'h01,
        OP_READ   = 8'h03,
        OP_FAST   = 8'h0B,
        OP_DUAL   = 8'h3B,
        OP_SECT   = 8'h20,
        OP_BLK_A  = 8'h52,
        OP_BLK_B  = 8'hD8,
        OP_CHIP_A = 8'h60,
        OP_CHIP_B = 8'hC7,
        OP_PAGE   = 8'h02,
        OP_SLEEP  = 8'hB9,
        OP_WAKE   = 8'hAB,
        OP_IDENT  = 8'h9F,
        OP_MAKER  = 8'h90,
        OP_SECRD  = 8'h2B,
        OP_SECWR  = 8'h2F
    } opcode_e;

    typedef enum logic [2:0] {
        ST_READY = 3'b000,
        ST_BUSY  = 3'b001,
        ST_ENTER = 3'b010,
        ST_ASLP  = 3'b011,
        ST_WAKE  = 3'b100
    } core_e;

    typedef struct packed {
        logic [7:0]  op;
        logic [23:0] addr;
        logic [7:0]  dat;
    } frame_s;

endpackage : serial_flash_command_set_pkg

// [rtl/serial_flash_command_set_regs.svh]
// Timing figures and frame bit positions of the flash command layer.
// Assumes a 100 MHz core clock; counts derive from the figures below.
`ifndef SERIAL_FLASH_COMMAND_SET_REGS_SVH
`define SERIAL_FLASH_COMMAND_SET_REGS_SVH

`define CLK_MHZ     100
`define STATUS_MS   40
`define PAGE_MS     3
`define BYTE_US     50
`define SECTOR_MS   200
`define BLOCK_S     2
`define CHIP_S      6
`define SLEEP_US    10
// 8.8 us held in ns
`define WAKE_NS     8800

`define SLEEP_CYC   (`SLEEP_US * `CLK_MHZ)
`define WAKE_CYC    (`WAKE_NS * `CLK_MHZ / 1000)

// Bit counts within a frame
`define OP_BITS     16'h0008
`define STORE_END   16'h0010
`define ADDR_END    16'h0020
`define FAST_END    16'h0028
`define BYTE_END    16'h0028
`define NO_OUT      16'hFFFF

// Status and security byte fields
`define ST_BUSY     0
`define ST_WEL      1
`define SEC_LOCK    1

`endif

// [testbench/flash_checker_properties.sv]
// Port checker of the flash command layer, bound into the design.
// Assumes clk/nrst as core domain and selN as link-side reset.
`timescale 1ns/1ps
`include "serial_flash_command_set_regs.svh"
module flash_checker #(parameter int unsigned CHIP_CYC = 100) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic serialClk,
    input wire logic selN,
    input wire logic serialIn,
    input wire logic pauseN,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic dualOut,
    input wire logic dualOutEn,
    input wire logic busyOut,
    input wire logic asleepOut
);
    localparam int SLEEP_MAX = `SLEEP_CYC + 8;
    localparam int WAKE_MAX  = `WAKE_CYC + 8;
    localparam int BUSY_MAX  = (int'(CHIP_CYC) > SLEEP_MAX ? int'(CHIP_CYC) : SLEEP_MAX) + 8;
    int busyRun_r;
    int busyRun_nxt;
    // Length of the current busy run outside sleep
    assign busyRun_nxt = (busyOut && !asleepOut) ? busyRun_r + 1 : 0;
    always_ff @(posedge clk) busyRun_r <= nrst ? busyRun_nxt : 0;
    sequence wakeDone;
        ##[0:WAKE_MAX] !busyOut;
    endsequence
    sequence pausedTwice;
        !pauseN ##1 !pauseN;
    endsequence
    AST_EN_DESEL: assert property (@(posedge clk) disable iff (!nrst)
        selN |-> !serialOutEn && !dualOutEn) else $error("enable while deselected");
    AST_EN_RISE: assert property (@(posedge clk) disable iff (!nrst)
        $rose(serialOutEn) |-> !selN) else $error("enable rose without select");
    AST_DUAL_PAIR: assert property (@(posedge clk) disable iff (!nrst)
        dualOutEn |-> serialOutEn) else $error("second line alone");
    AST_PAUSE_DROP: assert property (@(negedge serialClk) disable iff (selN)
        pausedTwice |-> !serialOutEn && !dualOutEn) else $error("driven while paused");
    AST_ASLEEP_BUSY: assert property (@(posedge clk) disable iff (!nrst)
        asleepOut |-> busyOut) else $error("asleep but not busy");
    AST_SLEEP_TIME: assert property (@(posedge clk) disable iff (!nrst)
        $rose(asleepOut) |-> busyRun_r <= SLEEP_MAX) else $error("sleep entry late");
    AST_WAKE_TIME: assert property (@(posedge clk) disable iff (!nrst)
        $fell(asleepOut) |-> wakeDone) else $error("wake too slow");
    AST_BUSY_BOUND: assert property (@(posedge clk) disable iff (!nrst)
        busyRun_r <= BUSY_MAX) else $error("busy too long");
endmodule : flash_checker
bind serial_flash_command_set flash_checker #(.CHIP_CYC(CHIP_CYC)) chk (.clk(clk),
    .nrst(nrst), .serialClk(serialClk), .selN(selN), .serialIn(serialIn), .pauseN(pauseN),
    .serialOut(serialOut), .serialOutEn(serialOutEn), .dualOut(dualOut),
    .dualOutEn(dualOutEn), .busyOut(busyOut), .asleepOut(asleepOut));

// [testbench/flash_host.sv]
// Host model of the flash link: frames on a 6 ns clock, idle between them.
// Assumes the bench calls xfer; reply bits are taken on rising edges.
`timescale 1ns/1ps
module flash_host (
    output logic      serialClk,
    output logic      selN,
    output logic      serialIn,
    output logic      pauseN,
    input  wire logic serialOut,
    input  wire logic dualOut
);
    // Late rise of select so the link side is cleared at start
    initial begin
        serialClk = 1'b0;
        selN = 1'b0;
        serialIn = 1'b0;
        pauseN = 1'b1;
        #1 selN = 1'b1;
    end
    task automatic xfer(input logic [47:0] tx, input int nb, input int nr,
                        output logic [7:0] rx, input int hp = -1);
        if ($time < 200000) #(200000 - $time);
        selN = 1'b0;
        for (int i = 0; i < nb + nr; i++) begin
            if (i == hp) begin
                #1 pauseN = 1'b0;
                repeat (3) begin
                    serialIn = ~serialIn;
                    #3 serialClk = 1'b1;
                    #3 serialClk = 1'b0;
                end
                #1 pauseN = 1'b1;
            end
            serialIn = (i < nb) ? tx[47 - i] : ~serialIn;
            #3 serialClk = 1'b1;
            // Two bits a clock on the two-line read
            if (i >= nb) rx = (tx[47:40] == 8'h3B) ? {rx[5:0], serialOut, dualOut}
                                                   : {rx[6:0], serialOut};
            #3 serialClk = 1'b0;
        end
        #3 selN = 1'b1;
        serialIn = ~serialIn;
        #60;
    endtask : xfer
endmodule : flash_host

// [testbench/serial_flash_command_set_bench.sv]
// Self-checking bench of the flash command layer.
// Assumes flash_host drives the link and the checker is bound in.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
module serial_flash_command_set_bench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    wire  sClk, selN, sIn, pauseN, sOut, sOutEn, dOut, dOutEn, busy, asleep;
    int   fail_count = 0;
    int   tests_run = 0;
    logic [7:0] rd;
    serial_flash_command_set #(.PAGE_CYC(100), .BYTE_CYC(40), .STATUS_CYC(50),
        .SECTOR_CYC(60), .CHIP_CYC(120)) dut (.clk(clk), .nrst(nrst),
        .serialClk(sClk), .selN(selN), .serialIn(sIn), .pauseN(pauseN), .serialOut(sOut),
        .serialOutEn(sOutEn), .dualOut(dOut), .dualOutEn(dOutEn), .busyOut(busy),
        .asleepOut(asleep));
    flash_host host (.serialClk(sClk), .selN(selN), .serialIn(sIn), .pauseN(pauseN),
        .serialOut(sOut), .dualOut(dOut));
    initial forever #5 clk = ~clk;
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic cmd(input logic [47:0] tx, input int nb, input int nr, input logic [7:0] e);
        host.xfer(tx, nb, nr, rd);
        if (nr > 0) `CHK(rd, e)
    endtask : cmd
    task automatic waitReady();
        for (int n = 0; n < 300; n++) begin
            host.xfer({8'h05, 40'h0}, 8, 8, rd);
            if (rd[0] === 1'b0) return;
        end
        `CHK(1'b1, 1'b0)
    endtask : waitReady
    task automatic t_prog();
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h05, 40'h0}, 8, 8, 8'h02);
        cmd({8'h04, 40'h0}, 8, 0, 8'h00);
        cmd({8'h05, 40'h0}, 8, 8, 8'h00);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h02, 24'h1, 16'h5A3C}, 48, 0, 8'h00);
        `CHK(busy, 1'b1)
        repeat (60) @(posedge clk);
        `CHK(busy, 1'b1)
        repeat (40) @(posedge clk);
        `CHK(busy, 1'b0)
        cmd({8'h03, 24'h1, 16'h0}, 32, 8, 8'h5A);
        cmd({8'h0B, 24'h1, 16'h0}, 40, 16, 8'h3C);
        cmd({8'h3B, 24'h1, 16'h0}, 40, 8, 8'h3C);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h20, 24'h0, 16'h0}, 32, 0, 8'h00);
        waitReady();
        cmd({8'h03, 24'h2, 16'h0}, 32, 8, 8'hFF);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h02, 24'h3, 16'h0F00}, 40, 0, 8'h00);
        repeat (30) @(posedge clk);
        `CHK(busy, 1'b1)
        repeat (15) @(posedge clk);
        `CHK(busy, 1'b0)
        cmd({8'h03, 24'h3, 16'h0}, 32, 8, 8'h0F);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'hC7, 40'h0}, 8, 0, 8'h00);
        waitReady();
        cmd({8'h03, 24'h3, 16'h0}, 32, 8, 8'hFF);
    endtask : t_prog
    task automatic t_ids();
        host.xfer({8'h9F, 40'h0}, 8, 8, rd, 4);
        `CHK(rd, 8'hA5)
        host.xfer({8'h9F, 40'h0}, 8, 8, rd, 10);
        `CHK(rd, 8'hA5)
        cmd({8'h90, 24'h1, 16'h0}, 32, 8, 8'h3C);
        cmd({8'h90, 24'h0, 16'h0}, 32, 8, 8'hA5);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h01, 8'hFC, 32'h0}, 16, 0, 8'h00);
        waitReady();
        cmd({8'h05, 40'h0}, 8, 8, 8'hFC);
        cmd({8'h06, 40'h0}, 8, 0, 8'h00);
        cmd({8'h2F, 40'h0}, 8, 0, 8'h00);
        cmd({8'h2B, 40'h0}, 8, 8, 8'h02);
    endtask : t_ids
    task automatic t_sleep();
        cmd({8'hB9, 40'h0}, 8, 0, 8'h00);
        repeat (1010) @(posedge clk);
        `CHK(asleep, 1'b1)
        cmd({8'hAB, 40'h0}, 32, 8, 8'h13);
        repeat (890) @(posedge clk);
        `CHK(busy, 1'b0)
    endtask : t_sleep
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        #600us;
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_prog();
        t_ids();
        t_sleep();
        end_sim();
    end
endmodule : serial_flash_command_set_bench
